// File: upp_map.svh
// register offsets, field positions, reset values and sync depth for the user pin port
// assumes it is included once by the package and the modules that need the numbers
`ifndef UPP_MAP_SVH
`define UPP_MAP_SVH

// register offsets on the control port
`define UPP_OFS_PIN_STATE       8'h03
`define UPP_OFS_PIN_DIRECTION   8'h04
`define UPP_OFS_PIN_IRQ_ENABLE  8'h05
`define UPP_OFS_PIN_IRQ_EDGE    8'h06

// field position of the three pins inside each register
`define UPP_PIN_MSB             7
`define UPP_PIN_LSB             5
`define UPP_PIN_COUNT           3

// reset values of the pin fields
`define UPP_RST_PIN_STATE       3'h7
`define UPP_RST_PIN_DIRECTION   3'h7
`define UPP_RST_PIN_IRQ_ENABLE  3'h0
`define UPP_RST_PIN_IRQ_EDGE    3'h0

// stages of the pin input synchroniser
`define UPP_SYNC_STAGES         3

// cycles after reset before pin edges may latch; covers the synchroniser
// filling and the previous-level flop catching up with it
`define UPP_SETTLE_CYCLES       3'h5

`endif

// File: upp_pkg.sv
// types shared by the user pin port modules
// assumes upp_map.svh sits in the same folder
`include "upp_map.svh"

package upp_pkg;

  // drive side of the three user pins
  typedef struct packed {
    logic [`UPP_PIN_COUNT-1:0] drive;
    logic [`UPP_PIN_COUNT-1:0] enable;
  } upp_pin_out_type;

  // software controlled configuration of the pins
  typedef struct packed {
    logic [`UPP_PIN_COUNT-1:0] out_value;
    logic [`UPP_PIN_COUNT-1:0] direction;
    logic [`UPP_PIN_COUNT-1:0] irq_enable;
    logic [`UPP_PIN_COUNT-1:0] irq_edge_select;
  } upp_cfg_type;

endpackage

// File: upp_sync.sv
// three-stage synchroniser with agreement filter for one asynchronous pin
// assumes clock_i is the system clock and the input is asynchronous to it
`timescale 1ns/10ps
`include "upp_map.svh"

module upp_sync
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // asynchronous pin and its filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  logic [`UPP_SYNC_STAGES-1:0] stage;

  // shift chain; only the second flop reads the first
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      stage <= '0;
    else
      stage <= {stage[`UPP_SYNC_STAGES-2:0], pin_i};
  end

  // the level moves only once the second and third stages agree
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      level_o <= 1'b0;
    else if (stage[1] == stage[2])
      level_o <= stage[2];
  end

endmodule

// File: upp_port.sv
// three user pins with direction control, level readback and edge interrupts
// assumes a register access port decoded from the serial control interface,
// one access per strobe, and other interrupt sources latched elsewhere
`timescale 1ns/10ps
`include "upp_map.svh"

module upp_port
  import upp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // register access port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // user pins 7 down to 5 (bit 2 is pin 7)
  input  wire logic [2:0]  user_pin_i,
  output logic [2:0]       user_pin_o,
  output logic [2:0]       user_pin_oe_o,
  // other interrupt sources, bits 4..0 of the source register
  input  wire logic [4:0]  other_irq_i,
  // device interrupt, active low
  output logic             irq_n_o
);

  upp_cfg_type      cfg;
  upp_pin_out_type  pins;
  logic [2:0]       level;
  logic [2:0]       level_prev;
  logic [2:0]       edge_hit;
  logic [2:0]       irq_latch;
  logic             state_read;
  logic [7:0]       next_rdata;
  logic [2:0]       settle;
  logic             settled;

  // pin synchronisers
  // one synchroniser per pin keeps false edges out of the detectors
  genvar gi;
  generate
    for (gi = 0; gi < `UPP_PIN_COUNT; gi = gi + 1)
    begin : g_sync
      upp_sync u_sync
      (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (user_pin_i[gi]),
        .level_o   (level[gi])
      );
    end
  endgenerate

  // configuration writes
  // written bits 7:5 land in the field of the addressed register
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      cfg.out_value       <= `UPP_RST_PIN_STATE;
      cfg.direction       <= `UPP_RST_PIN_DIRECTION;
      cfg.irq_enable      <= `UPP_RST_PIN_IRQ_ENABLE;
      cfg.irq_edge_select <= `UPP_RST_PIN_IRQ_EDGE;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `UPP_OFS_PIN_STATE)
        cfg.out_value <= reg_wdata_i[`UPP_PIN_MSB:`UPP_PIN_LSB];
      else if (reg_addr_i == `UPP_OFS_PIN_DIRECTION)
        cfg.direction <= reg_wdata_i[`UPP_PIN_MSB:`UPP_PIN_LSB];
      else if (reg_addr_i == `UPP_OFS_PIN_IRQ_ENABLE)
        cfg.irq_enable <= reg_wdata_i[`UPP_PIN_MSB:`UPP_PIN_LSB];
      else if (reg_addr_i == `UPP_OFS_PIN_IRQ_EDGE)
        cfg.irq_edge_select <= reg_wdata_i[`UPP_PIN_MSB:`UPP_PIN_LSB];
    end
  end

  // pin drive
  // reset direction is all inputs, so nothing drives until software says so
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pins.drive  <= '0;
      pins.enable <= '0;
    end
    else
    begin
      pins.drive  <= cfg.out_value;
      pins.enable <= ~cfg.direction;
    end
  end

  assign user_pin_o    = pins.drive;
  assign user_pin_oe_o = pins.enable;

  // previous filtered level for edge detection
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      level_prev <= '0;
    else
      level_prev <= level;
  end

  // settle counter after reset
  // the synchroniser restarts from zero, so a pin idling high would look
  // like a rising edge a few cycles after reset; software may enable the
  // interrupt on the very first access, so edges stay masked until the
  // filtered level and its previous copy both follow the real pin
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      settle <= 3'h0;
    else if (settle != `UPP_SETTLE_CYCLES)
      settle <= settle + 3'h1;
  end

  assign settled = (settle == `UPP_SETTLE_CYCLES);

  // edge select, inputs only
  // a pin driven as output never qualifies, whatever its enable says
  // limitation: a pulse shorter than about two clocks may be filtered out,
  // and several edges between two reads of the state register collapse
  // into one latched indication
  genvar ei;
  generate
    for (ei = 0; ei < `UPP_PIN_COUNT; ei = ei + 1)
    begin : g_edge
      logic rise;
      logic fall;
      logic armed;

      // both edges of the filtered level, seen in the same cycle it moves
      assign rise = level[ei] & ~level_prev[ei];
      assign fall = level_prev[ei] & ~level[ei];

      // only enabled input pins may fire, and only once the filter settled
      assign armed = settled & cfg.irq_enable[ei] & cfg.direction[ei];

      // select one means falling, zero (the reset value) means rising
      assign edge_hit[ei] = armed & (cfg.irq_edge_select[ei] ? fall : rise);
    end
  endgenerate

  assign state_read = reg_rd_i && (reg_addr_i == `UPP_OFS_PIN_STATE);

  // latch and re-arm
  // an edge in the read cycle wins, so it is never lost by the clear
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      irq_latch <= '0;
    else
      irq_latch <= (state_read ? 3'h0 : irq_latch) | edge_hit;
  end

  // interrupt merge
  // registered so the pin cannot glitch on decode hazards
  // pin to interrupt latency is about six clocks: three synchroniser flops,
  // the agreement filter, the latch and this output flop
  // the other sources are levels held outside, so they stay visible here
  // until their own owner clears them
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      irq_n_o <= 1'b1;
    else
      irq_n_o <= ~((|irq_latch) | (|other_irq_i));
  end

  // read decode
  // unmapped offsets and reserved bits read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_addr_i == `UPP_OFS_PIN_STATE)
      next_rdata = {level, other_irq_i};
    else if (reg_addr_i == `UPP_OFS_PIN_DIRECTION)
      next_rdata[`UPP_PIN_MSB:`UPP_PIN_LSB] = cfg.direction;
    else if (reg_addr_i == `UPP_OFS_PIN_IRQ_ENABLE)
      next_rdata[`UPP_PIN_MSB:`UPP_PIN_LSB] = cfg.irq_enable;
    else if (reg_addr_i == `UPP_OFS_PIN_IRQ_EDGE)
      next_rdata[`UPP_PIN_MSB:`UPP_PIN_LSB] = cfg.irq_edge_select;
  end

  // read data held until the next read strobe
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
  end

endmodule

// File: upp_port_monitor.sv
// checker on the user pin port outputs
// assumes it is bound to every upp_port
`timescale 1ns/10ps
module upp_port_monitor
(
  // clock, reset and register port
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins and interrupts
  input wire logic [2:0] user_pin_i,
  input wire logic [2:0] user_pin_o,
  input wire logic [2:0] user_pin_oe_o,
  input wire logic [4:0] other_irq_i,
  input wire logic       irq_n_o
);
  logic       rd3;
  logic [3:0] quiet;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  assign rd3 = reg_rd_i && reg_addr_i == 8'h03;
  // cycles since a pin moved; saturates so an old edge never looks new
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || $changed(user_pin_i))
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst_i |=> user_pin_oe_o == 3'h0 && irq_n_o) else $error("pin driven in reset");
  a_read_other: assert property (
    rd3 |=> reg_rdata_o[4:0] == $past(other_irq_i)) else $error("bad source bits");
  a_read_hole: assert property (
    reg_rd_i && (reg_addr_i < 8'h03 || reg_addr_i > 8'h06) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_dir_oe: assert property (
    reg_wr_i && reg_addr_i == 8'h04 |-> ##2
    {user_pin_oe_o, 5'h00} == (~$past(reg_wdata_i, 2) & 8'hE0)) else $error("bad enable");
  a_out_value: assert property (
    reg_wr_i && reg_addr_i == 8'h03 |-> ##2 (({user_pin_o, 5'h00} ^ $past(reg_wdata_i, 2))
    & {user_pin_oe_o, 5'h00}) == 8'h00) else $error("bad drive");
  a_other_or: assert property (
    other_irq_i != 5'h00 |=> !irq_n_o) else $error("source not ored");
  a_irq_hold: assert property (
    !irq_n_o && $past(other_irq_i) == 5'h00 && !rd3 && !$past(rd3) |=> !irq_n_o)
    else $error("latch lost");
  a_irq_clear: assert property (
    rd3 && quiet >= 4'h8 && other_irq_i == 5'h00 ##1 other_irq_i == 5'h00 |=> irq_n_o)
    else $error("latch kept");
  c_pin_irq: cover property ($fell(irq_n_o) && other_irq_i == 5'h00);
  c_clear: cover property (rd3 && !irq_n_o);
  c_dir: cover property (reg_wr_i && reg_addr_i == 8'h04);
endmodule
bind upp_port upp_port_monitor u_mon (.*);

// File: upp_pins_model.sv
// board circuit on the three user pins
// assumes the board always drives a released pin
`timescale 1ns/10ps
module upp_pins_model
  import upp_pkg::*;
(
  // port drive and board level in, wire level out
  input  wire upp_pin_out_type pins_i,
  input  wire logic [2:0]      board_i,
  output logic [2:0]           level_o
);
  assign level_o = (pins_i.enable & pins_i.drive) | (~pins_i.enable & board_i);
endmodule

// File: upp_port_tb.sv
// bench: register tasks and a board model on the pins
// assumes 200 MHz and inputs moved on the falling edge
`timescale 1ns/10ps
module upp_port_tb;
  // port signals keep the port names
  logic       clock_i, sys_rst_i, reg_wr_i, reg_rd_i, irq_n_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [2:0] user_pin_i, user_pin_o, user_pin_oe_o, board;
  logic [4:0] other_irq_i;
  int         err_total, total_checks;
  upp_port u_dut (.*);
  upp_pins_model u_board (.pins_i({user_pin_o, user_pin_oe_o}), .board_i(board),
    .level_o(user_pin_i));
  // free running clock
  initial
  begin
    clock_i = 1'h0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ik(input logic e);
    chk({7'h00, irq_n_o}, {7'h00, e});
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // strobes last one cycle, so two calls never touch a strobe in one step
  task automatic wr(input logic [7:0] a, d);
    w(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    w(1);
    reg_wr_i = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    w(1);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    w(1);
    reg_rd_i = 1'h0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, far beyond the sequence length
  initial
  begin
    #20000;
    err_total++;
    print_verdict();
  end
  initial
  begin
    {err_total, total_checks} = 0;
    {sys_rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 19'h40000;
    other_irq_i = 5'h00;
    board = 3'h5;
    w(10);
    sys_rst_i = 1'h0;
    chk({5'h00, user_pin_oe_o}, 8'h00);
    rd(8'h04, 8'hE0);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h03, 8'hA0);
    wr(8'h03, 8'h80);
    board = 3'h3;
    wr(8'h04, 8'h40);
    w(8);
    rd(8'h03, 8'hC0);
    board = 3'h0;
    wr(8'h04, 8'hE0);
    w(10);
    wr(8'h05, 8'hE0);
    w(10);
    ik(1'h1);
    board = 3'h2;
    w(10);
    ik(1'h0);
    board = 3'h6;
    w(10);
    rd(8'h03, 8'hC0);
    w(2);
    ik(1'h1);
    board = 3'h7;
    w(10);
    ik(1'h0);
    rd(8'h03, 8'hE0);
    wr(8'h06, 8'hE0);
    board = 3'h0;
    w(10);
    ik(1'h0);
    rd(8'h03, 8'h00);
    wr(8'h06, 8'h00);
    wr(8'h03, 8'h20);
    wr(8'h04, 8'hC0);
    w(10);
    ik(1'h1);
    other_irq_i = 5'h04;
    w(2);
    ik(1'h0);
    rd(8'h03, 8'h24);
    other_irq_i = 5'h00;
    w(3);
    ik(1'h1);
    print_verdict();
  end
endmodule
